// ---- src/servo_ctrl_consts.svh ----
/*
 * Register offsets, reset values and timing counts of the servo mode/stop block.
 * Assumes a 25 MHz pclk and 32-bit APB with word-aligned registers.
 */
`ifndef SERVO_CTRL_CONSTS_SVH
`define SERVO_CTRL_CONSTS_SVH

// ****************************************
// register map (byte addresses)
// ****************************************
`define OFS_MODE_SEL     12'h000
`define OFS_DIS_STOP     12'h004
`define OFS_ESTOP_STOP   12'h008
`define OFS_RAPID_MS     12'h00C
`define OFS_SLOW_MS      12'h010
`define OFS_SPEED_CMD    12'h014
`define OFS_STATUS       12'h018

// ****************************************
// reset values
// ****************************************
`define RST_MODE_SEL     16'h0000
`define RST_DIS_STOP     16'h0000
`define RST_ESTOP_STOP   16'h0000
`define RST_RAPID_MS     16'h01F4
`define RST_SLOW_MS      16'h03E8
`define RST_SPEED_CMD    16'h0000

// ****************************************
// timing
// ****************************************
`define CLK_HZ           25000000
`define MS_PER_S         1000
`define CYC_PER_MS       (`CLK_HZ / `MS_PER_S)

// ****************************************
// status field positions
// ****************************************
`define ST_READY_BIT     0
`define ST_DRIVE_BIT     1
`define ST_MODE_LSB      4
`define ST_STATE_LSB     8
`define ST_KIND_LSB      12
`define ST_SPEED_LSB     16

`endif

// ---- src/servo_ctrl_pkg.sv ----
/*
 * Types shared by the servo mode/stop block.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package servo_ctrl_pkg;

   typedef enum logic [1:0] {MODE_POS, MODE_SPEED, MODE_TORQUE} ctrl_mode_e;
   typedef enum logic [1:0] {ST_OFF, ST_RUN, ST_DECEL, ST_HOLD} drive_state_e;
   typedef enum logic [1:0] {STOP_FREE, STOP_RAPID, STOP_SLOW} stop_kind_e;

endpackage : servo_ctrl_pkg

// ---- src/pin_sync3.sv ----
/*
 * Three-stage synchroniser for asynchronous pins.
 * Assumes the pins are levels; the output moves only when stages two and three agree.
 */
`timescale 1ns/1ps

module pin_sync3 #(
   parameter int W = 1
) (
   input  wire logic         pclk,
   input  wire logic         presetn,
   input  wire logic [W-1:0] pin,
   output logic      [W-1:0] level
);

   logic [W-1:0] s1_q;
   logic [W-1:0] s2_q;
   logic [W-1:0] s3_q;
   logic [W-1:0] lvl_q;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s1_q  <= '0;
         s2_q  <= '0;
         s3_q  <= '0;
         lvl_q <= '0;
      end else begin
         s1_q <= pin;
         s2_q <= s1_q;
         s3_q <= s2_q;
         for (int i = 0; i < W; i++) begin
            if (s2_q[i] == s3_q[i]) begin
               lvl_q[i] <= s3_q[i];
            end
         end
      end
   end

   assign level = lvl_q;

endmodule : pin_sync3

// ---- src/servo_mode_stop.sv ----
/*
 * Control-mode selection and enable/stop sequencing of a servo drive, with an APB slave
 * for its settings. Assumes active-high function-bit pins from IO or a comms block,
 * a single 25 MHz pclk, and an APB master that keeps psel/penable legal.
 */
`timescale 1ns/1ps
`include "servo_ctrl_consts.svh"

module servo_mode_stop
   import servo_ctrl_pkg::*;
#(
   parameter logic [15:0] RATED_SPEED = 16'h0BB8
) (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        servo_enable_in,
   input  wire logic        emergency_stop_in,
   input  wire logic        fault_in,
   input  wire logic        mode_switch_bit0,
   input  wire logic        mode_switch_bit1,
   output logic             servo_ready_out,
   output logic             cmd_accept,
   output logic             drive_enable,
   output logic [1:0]       active_mode,
   output logic [15:0]      speed_ref
);

   // ****************************************
   // state
   // ****************************************
   typedef struct packed {
      logic [15:0]  mode_sel;
      logic [15:0]  dis_stop;
      logic [15:0]  estop_stop;
      logic [15:0]  rapid_ms;
      logic [15:0]  slow_ms;
      logic [15:0]  speed_cmd;
      logic [31:0]  rdata;
      logic         ready_ack;
      logic         slverr;
      drive_state_e st;
      stop_kind_e   kind;
      logic         keep_en;
      logic [31:0]  ramp_acc;
      logic [31:0]  ramp_lim;
      logic [15:0]  speed;
      ctrl_mode_e   mode;
      logic         ready;
      logic         drive_en;
   } state_s;

   state_s s_q;
   state_s s_d;

   logic [4:0] pins_s;
   logic       en_s;
   logic       estop_s;
   logic       fault_s;
   logic       sw0_s;
   logic       sw1_s;

   pin_sync3 #(.W(5)) u_sync (
      .pclk    (pclk),
      .presetn (presetn),
      .pin     ({mode_switch_bit1, mode_switch_bit0, fault_in, emergency_stop_in,
                 servo_enable_in}),
      .level   (pins_s)
   );

   assign en_s    = pins_s[0];
   assign estop_s = pins_s[1];
   assign fault_s = pins_s[2];
   assign sw0_s   = pins_s[3];
   assign sw1_s   = pins_s[4];

   // ****************************************
   // decoding helpers
   // ****************************************
   function automatic ctrl_mode_e mode_decode(input logic [15:0] sel, input logic b0,
                                              input logic b1);
      ctrl_mode_e m;
      m = MODE_POS;
      unique case (sel)
         16'h0000: m = MODE_POS;
         16'h0001: m = MODE_SPEED;
         16'h0002: m = MODE_TORQUE;
         16'h0003: m = b0 ? MODE_TORQUE : MODE_POS;
         16'h0004: m = b0 ? MODE_SPEED : MODE_POS;
         16'h0005: m = b0 ? MODE_TORQUE : MODE_SPEED;
         16'h0006: begin
            // both low or both high is not in the table: fall back to position
            if (b1 && !b0) begin
               m = MODE_SPEED;
            end else if (!b1 && b0) begin
               m = MODE_TORQUE;
            end else begin
               m = MODE_POS;
            end
         end
         default: m = MODE_POS;
      endcase
      return m;
   endfunction : mode_decode

   // returns {keep enabled, kind}; out-of-range codes act as free rotation
   function automatic logic [2:0] stop_decode(input logic [15:0] opt, input logic allow_keep);
      logic [2:0] r;
      r = {1'b0, STOP_FREE};
      unique case (opt)
         16'h0001: r = {1'b0, STOP_RAPID};
         16'h0002: r = {1'b0, STOP_SLOW};
         16'h0003: r = allow_keep ? {1'b1, STOP_RAPID} : {1'b0, STOP_FREE};
         16'h0004: r = allow_keep ? {1'b1, STOP_SLOW} : {1'b0, STOP_FREE};
         default:  r = {1'b0, STOP_FREE};
      endcase
      return r;
   endfunction : stop_decode

   // ****************************************
   // next state
   // ****************************************
   logic [2:0]  dis_dec;
   logic [2:0]  est_dec;
   logic [2:0]  pick;
   logic [15:0] t_ms;
   logic [31:0] acc_nx;
   logic        setup;
   logic        access;

   assign dis_dec = stop_decode(s_q.dis_stop, 1'b0);
   assign est_dec = stop_decode(s_q.estop_stop, 1'b1);
   // ready_ack in the term keeps a held setup from being answered twice
   assign setup   = psel && !penable && !s_q.ready_ack;
   assign access  = psel && penable && s_q.ready_ack;

   always_comb begin
      s_d    = s_q;
      pick   = 3'b000;
      t_ms   = 16'h0000;
      acc_nx = 32'h0000_0000;

      // apb: read data and answer prepared in setup, write lands at the access edge
      s_d.ready_ack = setup;
      // error flag lives one cycle so pslverr leaves a flop directly
      s_d.slverr    = 1'b0;
      if (setup) begin
         s_d.rdata  = 32'h0000_0000;
         unique case (paddr)
            `OFS_MODE_SEL:   s_d.rdata = {16'h0000, s_q.mode_sel};
            `OFS_DIS_STOP:   s_d.rdata = {16'h0000, s_q.dis_stop};
            `OFS_ESTOP_STOP: s_d.rdata = {16'h0000, s_q.estop_stop};
            `OFS_RAPID_MS:   s_d.rdata = {16'h0000, s_q.rapid_ms};
            `OFS_SLOW_MS:    s_d.rdata = {16'h0000, s_q.slow_ms};
            `OFS_SPEED_CMD:  s_d.rdata = {16'h0000, s_q.speed_cmd};
            `OFS_STATUS: begin
               s_d.rdata[`ST_READY_BIT]                  = s_q.ready;
               s_d.rdata[`ST_DRIVE_BIT]                  = s_q.drive_en;
               s_d.rdata[`ST_MODE_LSB +: 2]              = s_q.mode;
               s_d.rdata[`ST_STATE_LSB +: 2]             = s_q.st;
               s_d.rdata[`ST_KIND_LSB +: 2]              = s_q.kind;
               s_d.rdata[`ST_SPEED_LSB +: 16]            = s_q.speed;
            end
            default: s_d.slverr = 1'b1;
         endcase
      end
      if (access && pwrite) begin
         unique case (paddr)
            `OFS_MODE_SEL:   s_d.mode_sel   = pwdata[15:0];
            `OFS_DIS_STOP:   s_d.dis_stop   = pwdata[15:0];
            `OFS_ESTOP_STOP: s_d.estop_stop = pwdata[15:0];
            `OFS_RAPID_MS:   s_d.rapid_ms   = pwdata[15:0];
            `OFS_SLOW_MS:    s_d.slow_ms    = pwdata[15:0];
            `OFS_SPEED_CMD:  s_d.speed_cmd  = pwdata[15:0];
            default: ;
         endcase
      end

      s_d.mode = mode_decode(s_q.mode_sel, sw0_s, sw1_s);

      // shutdown cause priority: fault, then estop, then disable
      if (fault_s) begin
         pick = {1'b0, STOP_FREE};
      end else if (estop_s) begin
         pick = est_dec;
      end else begin
         pick = dis_dec;
      end

      unique case (s_q.st)
         ST_OFF: begin
            s_d.speed = 16'h0000;
            if (en_s && !estop_s && !fault_s) begin
               s_d.st = ST_RUN;
            end
         end
         ST_RUN: begin
            s_d.speed = s_q.speed_cmd;
            // the ramp starts from the present speed, so a slower motor stops sooner
            if (fault_s || estop_s || !en_s) begin
               s_d.kind     = stop_kind_e'(pick[1:0]);
               s_d.keep_en  = pick[2];
               s_d.ramp_acc = 32'h0000_0000;
               s_d.speed    = s_q.speed;
               t_ms         = (pick[1:0] == STOP_SLOW) ? s_q.slow_ms : s_q.rapid_ms;
               s_d.ramp_lim = 32'(t_ms) * 32'(`CYC_PER_MS);
               s_d.st       = (pick[1:0] == STOP_FREE) ? ST_OFF : ST_DECEL;
            end
         end
         ST_DECEL: begin
            // one speed unit per lim/rated cycles: rated speed reaches zero in the set time
            acc_nx = s_q.ramp_acc + 32'(RATED_SPEED);
            if (fault_s) begin
               s_d.st = ST_OFF;
            end else if (s_q.speed == 16'h0000 || s_q.ramp_lim == 32'h0000_0000) begin
               s_d.speed = 16'h0000;
               s_d.st    = s_q.keep_en ? ST_HOLD : ST_OFF;
            end else if (acc_nx >= s_q.ramp_lim) begin
               s_d.ramp_acc = acc_nx - s_q.ramp_lim;
               s_d.speed    = s_q.speed - 16'h0001;
            end else begin
               s_d.ramp_acc = acc_nx;
            end
         end
         ST_HOLD: begin
            // only the enable input or a fault leaves hold; a cleared estop does not
            s_d.speed = 16'h0000;
            if (!en_s || fault_s) begin
               s_d.st = ST_OFF;
            end
         end
      endcase

      s_d.ready    = (s_d.st == ST_RUN);
      s_d.drive_en = (s_d.st != ST_OFF);
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_q            <= '0;
         s_q.mode_sel   <= `RST_MODE_SEL;
         s_q.dis_stop   <= `RST_DIS_STOP;
         s_q.estop_stop <= `RST_ESTOP_STOP;
         s_q.rapid_ms   <= `RST_RAPID_MS;
         s_q.slow_ms    <= `RST_SLOW_MS;
         s_q.speed_cmd  <= `RST_SPEED_CMD;
         s_q.st         <= ST_OFF;
         s_q.kind       <= STOP_FREE;
         s_q.mode       <= MODE_POS;
      end else begin
         s_q <= s_d;
      end
   end

   // ****************************************
   // outputs
   // ****************************************
   assign prdata          = s_q.rdata;
   assign pready          = s_q.ready_ack;
   assign pslverr         = s_q.slverr;
   assign servo_ready_out = s_q.ready;
   assign cmd_accept      = s_q.ready;
   assign drive_enable    = s_q.drive_en;
   assign active_mode     = s_q.mode;
   assign speed_ref       = s_q.speed;

   // ****************************************
   // checks
   // ****************************************
   a_apb_answer: assert property (@(posedge pclk) disable iff (!presetn)
      psel && !penable && !pready |=> pready)
      else $error("apb setup not answered next cycle");
   a_mode_fixed: assert property (@(posedge pclk) disable iff (!presetn)
      s_q.mode_sel == 16'h0002 |=> active_mode == MODE_TORQUE)
      else $error("torque mode not selected");
   a_mode_hyb4: assert property (@(posedge pclk) disable iff (!presetn)
      s_q.mode_sel == 16'h0004 && !sw0_s |=> active_mode == MODE_POS)
      else $error("mode 4 without switch not position");
   a_mode_hyb6: assert property (@(posedge pclk) disable iff (!presetn)
      s_q.mode_sel == 16'h0006 && sw1_s && !sw0_s |=> active_mode == MODE_SPEED)
      else $error("mode 6 speed decode wrong");
   a_ready_run: assert property (@(posedge pclk) disable iff (!presetn)
      servo_ready_out |-> drive_enable && $past(en_s) && !$past(estop_s) && !$past(fault_s))
      else $error("ready without enable");
   a_arm_enable: assert property (@(posedge pclk) disable iff (!presetn)
      s_q.st == ST_OFF && en_s && !estop_s && !fault_s |=> servo_ready_out)
      else $error("enable did not arm drive");
   a_fault_free: assert property (@(posedge pclk) disable iff (!presetn)
      fault_s |=> !drive_enable)
      else $error("fault did not drop drive");
   a_stop_start: assert property (@(posedge pclk) disable iff (!presetn)
      s_q.st == ST_RUN && (estop_s || !en_s) |=> !servo_ready_out)
      else $error("shutdown cause ignored");
   a_decel_drive: assert property (@(posedge pclk) disable iff (!presetn)
      s_q.st == ST_DECEL && speed_ref != 16'h0000 && s_q.ramp_lim != 32'h0000_0000
         && !fault_s |=> drive_enable && s_q.st == ST_DECEL)
      else $error("drive dropped while decelerating");
   a_ramp_mono: assert property (@(posedge pclk) disable iff (!presetn)
      s_q.st == ST_DECEL ##1 s_q.st == ST_DECEL |-> speed_ref <= $past(speed_ref)
         && ($past(speed_ref) - speed_ref) <= 16'h0001)
      else $error("ramp not linear downward");
   a_hold_zero: assert property (@(posedge pclk) disable iff (!presetn)
      s_q.st == ST_HOLD |-> speed_ref == 16'h0000 && drive_enable && !servo_ready_out)
      else $error("hold state not at zero enabled");
   a_hold_exit: assert property (@(posedge pclk) disable iff (!presetn)
      s_q.st == ST_HOLD && !en_s |=> !drive_enable)
      else $error("hold not left on disable");

   c_run: cover property (@(posedge pclk) disable iff (!presetn)
      s_q.st == ST_RUN);
   c_decel_hold: cover property (@(posedge pclk) disable iff (!presetn)
      s_q.st == ST_DECEL ##1 s_q.st == ST_HOLD);
   c_decel_off: cover property (@(posedge pclk) disable iff (!presetn)
      s_q.st == ST_DECEL ##1 s_q.st == ST_OFF);
   c_free_stop: cover property (@(posedge pclk) disable iff (!presetn)
      s_q.st == ST_RUN ##1 s_q.st == ST_OFF);
   c_hold_off: cover property (@(posedge pclk) disable iff (!presetn)
      s_q.st == ST_HOLD ##1 s_q.st == ST_OFF);

endmodule : servo_mode_stop

// ---- test/host_io_model.sv ----
/*
 * Host side of the servo mode/stop block: drives the input function bits.
 * Assumes the bench posts requests; pins change just after a rising pclk edge.
 */
`timescale 1ns/1ps

module host_io_model (
   input  wire logic       pclk,
   input  wire logic       presetn,
   input  wire logic       en_req,
   input  wire logic       estop_req,
   input  wire logic       fault_req,
   input  wire logic [1:0] sw_req,
   output logic            servo_enable_in,
   output logic            emergency_stop_in,
   output logic            fault_in,
   output logic            mode_switch_bit0,
   output logic            mode_switch_bit1
);
   // levels only: the drive samples them through its synchroniser
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         servo_enable_in   <= 1'b0;
         emergency_stop_in <= 1'b0;
         fault_in          <= 1'b0;
         mode_switch_bit0  <= 1'b0;
         mode_switch_bit1  <= 1'b0;
      end else begin
         servo_enable_in   <= en_req;
         emergency_stop_in <= estop_req;
         fault_in          <= fault_req;
         mode_switch_bit0  <= sw_req[0];
         mode_switch_bit1  <= sw_req[1];
      end
   end
endmodule : host_io_model

// ---- test/test_servo_mode_stop.sv ----
/*
 * Self-checking bench of servo_mode_stop: APB tasks, mode table, arming and stop ramps.
 * Assumes the host model in host_io_model.sv and the consts header on the include path.
 */
`timescale 1ns/1ps
`include "servo_ctrl_consts.svh"

module test_servo_mode_stop;
   import servo_ctrl_pkg::*;

   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic        en_req, estop_req, fault_req;
   logic [1:0]  sw_req, amode;
   logic        en_pin, estop_pin, fault_pin, sw0_pin, sw1_pin;
   logic        ready, accept, drive;
   logic [15:0] sref;
   int          n_errors, num_checks;

   initial begin
      pclk = 1'b0;
      forever #20 pclk = ~pclk;
   end

   host_io_model host (.pclk(pclk), .presetn(presetn), .en_req(en_req),
      .estop_req(estop_req), .fault_req(fault_req), .sw_req(sw_req),
      .servo_enable_in(en_pin), .emergency_stop_in(estop_pin), .fault_in(fault_pin),
      .mode_switch_bit0(sw0_pin), .mode_switch_bit1(sw1_pin));

   servo_mode_stop #(.RATED_SPEED(16'h0BB8)) uut (.pclk(pclk), .presetn(presetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .servo_enable_in(en_pin),
      .emergency_stop_in(estop_pin), .fault_in(fault_pin), .mode_switch_bit0(sw0_pin),
      .mode_switch_bit1(sw1_pin), .servo_ready_out(ready), .cmd_accept(accept),
      .drive_enable(drive), .active_mode(amode), .speed_ref(sref));

   // ****************************************
   // helpers
   // ****************************************
   task automatic conclude;
      $display("checks %0d, mismatches %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : conclude

   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("wrong value %s: expected %h, seen %h", what, exp, seen);
      end
   endtask : chk

   task automatic tmo(input string what);
      n_errors++;
      $display("wrong value %s: expected an answer, seen a timeout", what);
      conclude();
   endtask : tmo

   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int k;
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      k = 0;
      do begin
         @(posedge pclk);
         k++;
      end while (pready !== 1'b1 && k < 20);
      if (pready !== 1'b1) tmo("pready");
      rd = prdata;
      er = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic wait_ready(input logic v);
      int k;
      k = 0;
      while (ready !== v && k < 50) begin
         @(posedge pclk);
         k++;
      end
      if (ready !== v) tmo("servo_ready_out");
   endtask : wait_ready

   function automatic logic [1:0] exp_mode(input int m, input logic [1:0] s);
      case (m)
         1: return 2'h1;
         2: return 2'h2;
         3: return s[0] ? 2'h2 : 2'h0;
         4: return s[0] ? 2'h1 : 2'h0;
         5: return s[0] ? 2'h2 : 2'h1;
         6: return (s == 2'h2) ? 2'h1 : ((s == 2'h1) ? 2'h2 : 2'h0);
         default: return 2'h0;
      endcase
   endfunction : exp_mode

   task automatic arm(input logic [31:0] spd);
      int k;
      apb(1'b1, `OFS_SPEED_CMD, spd);
      en_req <= 1'b1;
      wait_ready(1'b1);
      chk("cmd_accept", {31'h0, accept}, 32'h1);
      chk("drive on", {31'h0, drive}, 32'h1);
      k = 0;
      while (sref !== spd[15:0] && k < 100) begin
         @(posedge pclk);
         k++;
      end
      chk("speed_ref run", {16'h0, sref}, spd);
      apb(1'b0, `OFS_STATUS, 32'h0);
      chk("status run", rd & 32'h0000_0303, 32'h0000_0103);
   endtask : arm

   // exp_n 0 means a free-rotation stop
   task automatic stop_run(input int cause, input logic [31:0] spd, input int exp_n,
                           input logic keep);
      int   n;
      logic held;
      arm(spd);
      @(posedge pclk);
      if (cause == 0) en_req <= 1'b0;
      else if (cause == 1) estop_req <= 1'b1;
      else fault_req <= 1'b1;
      wait_ready(1'b0);
      n = 0;
      held = 1'b1;
      while (exp_n > 0 && sref !== 16'h0000 && n < 5000) begin
         @(posedge pclk);
         n++;
         if (drive !== 1'b1 && sref !== 16'h0000) held = 1'b0;
      end
      if (exp_n == 0) begin
         @(posedge pclk);
         chk("free drive", {31'h0, drive}, 32'h0);
      end else begin
         chk("ramp drive held", {31'h0, held}, 32'h1);
         chk("ramp length", {31'h0, n >= exp_n - 4 && n <= exp_n + 4}, 32'h1);
      end
      repeat (3) @(posedge pclk);
      chk("drive after stop", {31'h0, drive}, {31'h0, keep});
      if (keep) begin
         repeat (50) @(posedge pclk);
         chk("hold speed", {16'h0, sref}, 32'h0);
         chk("hold drive", {31'h0, drive}, 32'h1);
         apb(1'b0, `OFS_STATUS, 32'h0);
         chk("status hold", rd & 32'h0000_0303, 32'h0000_0302);
         en_req <= 1'b0;
         repeat (8) @(posedge pclk);
         chk("hold released", {31'h0, drive}, 32'h0);
      end
      en_req    <= 1'b0;
      estop_req <= 1'b0;
      fault_req <= 1'b0;
      repeat (10) @(posedge pclk);
   endtask : stop_run

   // ****************************************
   // main sequence
   // ****************************************
   initial begin
      int k;
      presetn = 1'b0;
      {psel, penable, pwrite, paddr, pwdata} = '0;
      {en_req, estop_req, fault_req, sw_req} = '0;
      n_errors = 0;
      num_checks = 0;
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, `OFS_MODE_SEL, 32'h0);
      chk("mode reset", rd, 32'h0);
      chk("mapped no error", {31'h0, er}, 32'h0);
      apb(1'b0, `OFS_DIS_STOP, 32'h0);
      chk("disable option reset", rd, 32'h0);
      apb(1'b0, `OFS_ESTOP_STOP, 32'h0);
      chk("estop option reset", rd, 32'h0);
      apb(1'b0, `OFS_RAPID_MS, 32'h0);
      chk("rapid reset", rd, 32'h0000_01F4);
      apb(1'b0, `OFS_SLOW_MS, 32'h0);
      chk("slow reset", rd, 32'h0000_03E8);
      apb(1'b1, `OFS_RAPID_MS, 32'hABCD_FFFF);
      apb(1'b0, `OFS_RAPID_MS, 32'h0);
      chk("rapid max", rd, 32'h0000_FFFF);
      apb(1'b0, 12'h01C, 32'h0);
      chk("unmapped error", {31'h0, er}, 32'h1);
      chk("unmapped read", rd, 32'h0);
      $display("test registers done");
      for (int m = 0; m < 7; m++) begin
         apb(1'b1, `OFS_MODE_SEL, m);
         for (int s = 0; s < 4; s++) begin
            sw_req <= 2'(s);
            k = 0;
            do begin
               @(posedge pclk);
               k++;
            end while (amode !== exp_mode(m, 2'(s)) && k < 12);
            chk("active_mode", {30'h0, amode}, {30'h0, exp_mode(m, 2'(s))});
         end
      end
      apb(1'b1, `OFS_MODE_SEL, 32'h0);
      sw_req <= 2'h0;
      $display("test modes done");
      apb(1'b1, `OFS_SPEED_CMD, 32'h0000_0028);
      estop_req <= 1'b1;
      en_req    <= 1'b1;
      repeat (20) @(posedge pclk);
      chk("arm refused", {30'h0, ready, drive}, 32'h0);
      chk("no command", {16'h0, sref}, 32'h0);
      en_req    <= 1'b0;
      estop_req <= 1'b0;
      repeat (10) @(posedge pclk);
      $display("test arming done");
      // 3 ms and 6 ms give 25 and 50 cycles per speed unit at the rated 3000
      apb(1'b1, `OFS_RAPID_MS, 32'h3);
      apb(1'b1, `OFS_SLOW_MS, 32'h6);
      for (int o = 0; o < 3; o++) begin
         apb(1'b1, `OFS_DIS_STOP, o);
         stop_run(0, 32'h28, (o == 0) ? 0 : 1000 * o, 1'b0);
      end
      $display("test disable stops done");
      apb(1'b1, `OFS_DIS_STOP, 32'h1);
      for (int o = 0; o < 5; o++) begin
         apb(1'b1, `OFS_ESTOP_STOP, o);
         stop_run(1, 32'h14, (o == 0) ? 0 : ((o % 2) ? 500 : 1000), o > 2);
      end
      $display("test emergency stops done");
      stop_run(2, 32'h14, 0, 1'b0);
      $display("test fault stop done");
      conclude();
   end
endmodule : test_servo_mode_stop
